/* File: design/power_sequencer.sv */
// Turn-on sequencing, power good and fault retry control
// What this block does
// - Retry code 101: five attempts, then latch off
// - Retry code 110: six attempts, then latch off
// - Retry code 111: retry forever until stopped
// - Attempts spaced by retry interval times unit
// - Interval field n decodes to 2^n units
// - Same interval for run-on and retry gap
// - Assert power good at on threshold
// - Below off threshold: negate, set status
// - Wait turn-on delay before ramp starts
// - Ramp output over programmed rise time
// - Timeout fault if undervoltage level unreached
// - Zero timeout limit disables the timeout
// - Decode two-bit fault response field
// - Retry code 000: stay off until cleared
// - Latched fault cleared by clears or off-on
`timescale 1ns/100ps
`default_nettype none
`include "seq_defs.svh"
module power_sequencer #(
   parameter int MS_CYCLES = `MS_NS / `CLK_NS
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Decoded command port
   input wire logic [7:0] cmd_code,
   input wire logic cmd_write,
   input wire logic [15:0] cmd_wdata,
   input wire logic cmd_read,
   output logic [15:0] cmd_rdata,
   output logic cmd_rvalid,
   output logic cmd_unsupported,
   // Control and fault clearing
   input wire logic output_enable_cmd,
   input wire logic clear_faults,
   input wire logic clear_fault_bit,
   input wire logic ext_fault,
   input wire logic [15:0] retry_unit_ms,
   input wire logic pgood_pin_enable,
   // Measured output and limits
   input wire logic [15:0] vout_code,
   input wire logic [15:0] vout_uv_limit,
   // Converter control and status
   output logic output_on,
   output logic ramp_active,
   output logic power_good_output,
   output logic pgood_status,
   output logic ton_fault_flag,
   output logic fault_latched
);
   cfg_if cfg ();

   seq_regs u_regs (
      .mclk(mclk),
      .nrst(nrst),
      .cmd_code(cmd_code),
      .cmd_write(cmd_write),
      .cmd_wdata(cmd_wdata),
      .cmd_read(cmd_read),
      .cmd_rdata(cmd_rdata),
      .cmd_rvalid(cmd_rvalid),
      .cmd_unsupported(cmd_unsupported),
      .cfg(cfg)
   );

   seq_pkg::state_type st_q, st_d;
   logic [31:0] div_q, div_d;
   logic [23:0] el_q, el_d, tmo_q, tmo_d, interval_ms;
   logic [2:0] tries_q, tries_d, retry, rtime;
   logic [1:0] resp;
   logic en_q, reached_q, reached_d, pgood_q, pgood_d, pgst_q, pgst_d;
   logic tflag_q, tflag_d, tick, clr, powered, tmo_hit, retry_ok;

   assign resp = cfg.resp[`RESP_MSB:`RESP_LSB];
   assign retry = cfg.resp[`RETRY_MSB:`RETRY_LSB];
   assign rtime = cfg.resp[`RTIME_MSB:`RTIME_LSB];
   // Unit from the separate time-unit setting, shifted by the field
   assign interval_ms = {8'h00, retry_unit_ms} << rtime;
   // Millisecond tick runs free, so the first millisecond may be short
   assign tick = (div_q == 32'(MS_CYCLES - 1));
   assign clr = clear_faults || clear_fault_bit ||
                (en_q && !output_enable_cmd);
   assign powered = (st_q == seq_pkg::ST_RAMP) || (st_q == seq_pkg::ST_ON);
   assign tmo_hit = powered && !reached_q && (cfg.ton_max != `ZERO_WORD) &&
                    (tmo_q >= {8'h00, cfg.ton_max});
   // Unlimited code never exhausts; code 000 never retries
   assign retry_ok = (retry == `RETRY_FOREVER) ||
                     ((retry != `RETRY_NONE) && (tries_q < retry));

   always_comb begin
      st_d = st_q;
      div_d = tick ? 32'h00000000 : div_q + 32'h00000001;
      el_d = tick ? el_q + `ONE_ELAPSED : el_q;
      tries_d = tries_q;
      case (st_q)
         seq_pkg::ST_OFF: begin
            if (output_enable_cmd) begin
               st_d = seq_pkg::ST_DELAY;
            end
         end
         seq_pkg::ST_DELAY: begin
            if (el_q >= {8'h00, cfg.on_delay}) begin
               st_d = seq_pkg::ST_RAMP;
            end
         end
         seq_pkg::ST_RAMP, seq_pkg::ST_ON: begin
            if (st_q == seq_pkg::ST_RAMP &&
                el_q >= {8'h00, cfg.on_ramp}) begin
               st_d = seq_pkg::ST_ON;
            end
            if (st_q == seq_pkg::ST_ON && reached_q) begin
               tries_d = `ZERO_TRIES;
            end
            if (tmo_hit || ext_fault) begin
               case (resp)
                  `RESP_IGNORE: st_d = st_d;
                  `RESP_RUN_RETRY: st_d = seq_pkg::ST_FAULT_RUN;
                  `RESP_OFF_RETRY: st_d = retry_ok ?
                     seq_pkg::ST_RETRY_WAIT : seq_pkg::ST_LATCHED;
                  default: st_d = seq_pkg::ST_LATCHED;
               endcase
            end
         end
         seq_pkg::ST_FAULT_RUN: begin
            if (el_q >= interval_ms) begin
               if (ext_fault || !reached_q) begin
                  st_d = retry_ok ? seq_pkg::ST_RETRY_WAIT :
                         seq_pkg::ST_LATCHED;
               end else begin
                  st_d = seq_pkg::ST_ON;
               end
            end
         end
         seq_pkg::ST_RETRY_WAIT: begin
            if (el_q >= interval_ms) begin
               st_d = seq_pkg::ST_DELAY;
               if (retry != `RETRY_FOREVER) begin
                  tries_d = tries_q + `ONE_TRY;
               end
            end
         end
         seq_pkg::ST_LATCHED: begin
            if (clr) begin
               st_d = seq_pkg::ST_OFF;
            end
         end
         default: st_d = seq_pkg::ST_OFF;
      endcase
      if (!output_enable_cmd) begin
         st_d = seq_pkg::ST_OFF;
      end
      if (clr) begin
         tries_d = `ZERO_TRIES;
      end
      if (st_d != st_q) begin
         el_d = `ZERO_ELAPSED;
      end
   end

   always_comb begin
      reached_d = reached_q;
      tmo_d = tmo_q;
      tflag_d = tflag_q;
      pgst_d = pgst_q;
      pgood_d = pgood_q;
      // Run-on keeps the reached level so its end can judge the fault
      if (!output_on) begin
         reached_d = 1'b0;
         tmo_d = `ZERO_ELAPSED;
      end else begin
         if (vout_code >= vout_uv_limit) begin
            reached_d = 1'b1;
         end
         if (tick && !reached_q) begin
            tmo_d = tmo_q + `ONE_ELAPSED;
         end
      end
      // Flags set by hardware win over a clear in the same cycle
      if (clr) begin
         tflag_d = 1'b0;
         pgst_d = 1'b0;
      end
      if (tmo_hit) begin
         tflag_d = 1'b1;
      end
      if (vout_code < cfg.pgood_off) begin
         pgst_d = 1'b1;
      end
      // Hysteresis between the two thresholds holds the last state
      if (!powered || !pgood_pin_enable) begin
         pgood_d = 1'b0;
      end else if (vout_code < cfg.pgood_off) begin
         pgood_d = 1'b0;
      end else if (vout_code >= cfg.pgood_on) begin
         pgood_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_q <= seq_pkg::ST_OFF;
         div_q <= 32'h00000000;
         el_q <= `ZERO_ELAPSED;
         tmo_q <= `ZERO_ELAPSED;
         tries_q <= `ZERO_TRIES;
         en_q <= 1'b0;
         reached_q <= 1'b0;
         pgood_q <= 1'b0;
         pgst_q <= 1'b0;
         tflag_q <= 1'b0;
      end else begin
         st_q <= st_d;
         div_q <= div_d;
         el_q <= el_d;
         tmo_q <= tmo_d;
         tries_q <= tries_d;
         en_q <= output_enable_cmd;
         reached_q <= reached_d;
         pgood_q <= pgood_d;
         pgst_q <= pgst_d;
         tflag_q <= tflag_d;
      end
   end

   assign output_on = powered || (st_q == seq_pkg::ST_FAULT_RUN);
   assign ramp_active = (st_q == seq_pkg::ST_RAMP);
   assign power_good_output = pgood_q;
   assign pgood_status = pgst_q;
   assign ton_fault_flag = tflag_q;
   assign fault_latched = (st_q == seq_pkg::ST_LATCHED);

   AST_PG_LOW_UNPOWERED: assert property (@(posedge mclk) disable iff (!nrst)
      !powered |=> !power_good_output) else $error("pg high unpowered");
   AST_PG_ON: assert property (@(posedge mclk) disable iff (!nrst)
      powered && pgood_pin_enable && vout_code >= cfg.pgood_on &&
      vout_code >= cfg.pgood_off |=> power_good_output)
      else $error("pg not asserted");
   AST_PG_OFF_STATUS: assert property (@(posedge mclk) disable iff (!nrst)
      vout_code < cfg.pgood_off |=> pgood_status && !power_good_output)
      else $error("pg off not flagged");
   AST_TMO_ZERO: assert property (@(posedge mclk) disable iff (!nrst)
      cfg.ton_max == `ZERO_WORD |-> !tmo_hit)
      else $error("timeout with zero limit");
   AST_TMO_FLAG: assert property (@(posedge mclk) disable iff (!nrst)
      tmo_hit |=> ton_fault_flag) else $error("timeout not flagged");
   AST_DELAY_HOLD: assert property (@(posedge mclk) disable iff (!nrst)
      st_q == seq_pkg::ST_DELAY && el_q < {8'h00, cfg.on_delay} &&
      output_enable_cmd |=> st_q == seq_pkg::ST_DELAY && !output_on)
      else $error("ramp started early");
   AST_RAMP_END: assert property (@(posedge mclk) disable iff (!nrst)
      ramp_active && el_q >= {8'h00, cfg.on_ramp} && output_enable_cmd &&
      !tmo_hit && !ext_fault |=> st_q == seq_pkg::ST_ON)
      else $error("ramp did not end");
   AST_RETRY_GAP: assert property (@(posedge mclk) disable iff (!nrst)
      st_q == seq_pkg::ST_RETRY_WAIT && el_q < interval_ms |=>
      st_q inside {seq_pkg::ST_RETRY_WAIT, seq_pkg::ST_OFF})
      else $error("retry too soon");
   AST_UNIT_ONE: assert property (@(posedge mclk) disable iff (!nrst)
      rtime == 3'h0 |-> interval_ms == {8'h00, retry_unit_ms})
      else $error("interval decode");
   AST_LIMITED_TRIES: assert property (@(posedge mclk) disable iff (!nrst)
      st_q == seq_pkg::ST_RETRY_WAIT && retry inside {3'h5, 3'h6} &&
      $stable(cfg.resp) |-> tries_q < retry)
      else $error("too many attempts");
   AST_NO_RETRY: assert property (@(posedge mclk) disable iff (!nrst)
      fault_latched && !clr && output_enable_cmd |=> fault_latched)
      else $error("latched fault left");
   AST_CLEAR_TRIES: assert property (@(posedge mclk) disable iff (!nrst)
      clr |=> tries_q == `ZERO_TRIES) else $error("tries kept");
endmodule
`default_nettype wire

/* File: design/seq_regs.sv */
// Command-word register store with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "seq_defs.svh"
module seq_regs (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Decoded command port
   input wire logic [7:0] cmd_code,
   input wire logic cmd_write,
   input wire logic [15:0] cmd_wdata,
   input wire logic cmd_read,
   output logic [15:0] cmd_rdata,
   output logic cmd_rvalid,
   output logic cmd_unsupported,
   // Stored configuration
   cfg_if.store cfg
);
   logic [15:0] word_q [`WORD_REGS];
   logic [15:0] word_d [`WORD_REGS];
   logic [7:0] resp_q, resp_d;
   logic [15:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d, unsup_q, unsup_d;
   logic [7:0] index;
   logic in_words;

   assign index = cmd_code - `CMD_PGOOD_ON;
   assign in_words = (cmd_code >= `CMD_PGOOD_ON) &&
                     (cmd_code <= `CMD_TON_MAX);

   genvar g;
   generate
      for (g = 0; g < `WORD_REGS; g++) begin : g_word
         always_comb begin
            word_d[g] = word_q[g];
            if (cmd_write && in_words && index == 8'(g)) begin
               word_d[g] = cmd_wdata;
            end
         end
         always_ff @(posedge mclk) begin
            if (!nrst) begin
               word_q[g] <= `RESET_WORD;
            end else begin
               word_q[g] <= word_d[g];
            end
         end
      end
   endgenerate

   always_comb begin
      resp_d = resp_q;
      rdata_d = rdata_q;
      rvalid_d = cmd_read;
      unsup_d = 1'b0;
      if (cmd_write && cmd_code == `CMD_TON_RESP) begin
         resp_d = cmd_wdata[7:0];
      end
      if (cmd_read) begin
         if (in_words) begin
            rdata_d = word_q[index[2:0]];
         end else if (cmd_code == `CMD_TON_RESP) begin
            rdata_d = {8'h00, resp_q};
         end else begin
            rdata_d = `ZERO_WORD;
         end
      end
      // Unknown codes are answered with zero and flagged, never stored
      if ((cmd_read || cmd_write) && !in_words &&
          cmd_code != `CMD_TON_RESP) begin
         unsup_d = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         resp_q <= `RESET_RESP;
         rdata_q <= `ZERO_WORD;
         rvalid_q <= 1'b0;
         unsup_q <= 1'b0;
      end else begin
         resp_q <= resp_d;
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         unsup_q <= unsup_d;
      end
   end

   assign cmd_rdata = rdata_q;
   assign cmd_rvalid = rvalid_q;
   assign cmd_unsupported = unsup_q;
   assign cfg.pgood_on = word_q[0];
   assign cfg.pgood_off = word_q[1];
   assign cfg.on_delay = word_q[2];
   assign cfg.on_ramp = word_q[3];
   assign cfg.ton_max = word_q[4];
   assign cfg.resp = resp_q;
endmodule
`default_nettype wire

/* File: shared/cfg_if.sv */
// Configuration values carried from the register store to the sequencer
`timescale 1ns/100ps
`default_nettype none
interface cfg_if;
   logic [15:0] pgood_on;
   logic [15:0] pgood_off;
   logic [15:0] on_delay;
   logic [15:0] on_ramp;
   logic [15:0] ton_max;
   logic [7:0] resp;
   modport store (output pgood_on, pgood_off, on_delay, on_ramp, ton_max,
      resp);
   modport user (input pgood_on, pgood_off, on_delay, on_ramp, ton_max,
      resp);
endinterface
`default_nettype wire

/* File: shared/seq_defs.svh */
// Command codes, field positions, reset values and timing figures
`ifndef SEQ_DEFS_SVH
`define SEQ_DEFS_SVH
`define CMD_PGOOD_ON 8'h5E
`define CMD_PGOOD_OFF 8'h5F
`define CMD_ON_DELAY 8'h60
`define CMD_ON_RAMP 8'h61
`define CMD_TON_MAX 8'h62
`define CMD_TON_RESP 8'h63
`define WORD_REGS 5
`define RESP_MSB 7
`define RESP_LSB 6
`define RETRY_MSB 5
`define RETRY_LSB 3
`define RTIME_MSB 2
`define RTIME_LSB 0
`define RESET_WORD 16'h0000
`define RESET_RESP 8'h00
`define RESP_IGNORE 2'h0
`define RESP_RUN_RETRY 2'h1
`define RESP_OFF_RETRY 2'h2
`define RESP_OFF_LATCH 2'h3
`define RETRY_NONE 3'h0
`define RETRY_FOREVER 3'h7
`define ZERO_WORD 16'h0000
`define ZERO_ELAPSED 24'h000000
`define ONE_ELAPSED 24'h000001
`define ZERO_TRIES 3'h0
`define ONE_TRY 3'h1
`define MS_NS 1000000
`define CLK_NS 8
`endif

/* File: shared/seq_pkg.sv */
// Types shared by the sequencer modules
package seq_pkg;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_DELAY,
      ST_RAMP,
      ST_ON,
      ST_FAULT_RUN,
      ST_RETRY_WAIT,
      ST_LATCHED
   } state_type;
endpackage

/* File: tb/pmbus_host_model.sv */
// Host model that reads and writes the command port one whole word at a time
`timescale 1ns/100ps
`default_nettype none
module pmbus_host_model (
   // Clock
   input wire logic mclk,
   // Command port
   output logic [7:0] cmd_code,
   output logic cmd_write,
   output logic [15:0] cmd_wdata,
   output logic cmd_read,
   input wire logic [15:0] cmd_rdata,
   input wire logic cmd_rvalid,
   input wire logic cmd_unsupported
);
   initial begin
      cmd_code = 8'h00;
      cmd_write = 1'b0;
      cmd_wdata = 16'h0000;
      cmd_read = 1'b0;
   end
   // Each strobe carries one complete 16-bit word
   task automatic wr_word(input logic [7:0] c, input logic [15:0] d);
      @(posedge mclk);
      cmd_code <= c;
      cmd_wdata <= d;
      cmd_write <= 1'b1;
      @(posedge mclk);
      cmd_write <= 1'b0;
      // Released lines show inverted data so a stale sample cannot pass
      cmd_wdata <= ~d;
      cmd_code <= ~c;
   endtask
   task automatic rd_word(input logic [7:0] c, output logic [15:0] d,
                          output logic [1:0] st);
      @(posedge mclk);
      cmd_code <= c;
      cmd_read <= 1'b1;
      @(posedge mclk);
      cmd_read <= 1'b0;
      cmd_code <= ~c;
      @(posedge mclk);
      d = cmd_rdata;
      st = {cmd_rvalid, cmd_unsupported};
   endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Bench: register access, turn-on timing, power good and fault retry cases
`timescale 1ns/100ps
`default_nettype none
`include "seq_defs.svh"
module tb_top;
   localparam int MS = 10;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, cmd_rdata, rd;
   logic [15:0] vout_code = 16'h0000;
   logic cmd_write, cmd_read, cmd_rvalid, cmd_unsupported, output_on;
   logic ramp_active, power_good_output, pgood_status, ton_fault_flag;
   logic fault_latched, bad;
   logic output_enable_cmd = 1'b0;
   logic clear_faults = 1'b0;
   logic clear_fault_bit = 1'b0;
   logic ext_fault = 1'b0;
   logic ramp_q = 1'b0;
   logic [1:0] st;
   logic [7:0] resps [5] = '{8'hA8, 8'hB0, 8'h80, 8'hE8, 8'h48};
   int exp_ramps [5] = '{6, 7, 1, 1, 2};
   int n_fail = 0;
   int compares = 0;
   int n_ramp = 0;
   int base = 0;
   int cycles = 0;
   int t, i;
   always #4 mclk = ~mclk;
   pmbus_host_model host (.mclk(mclk), .cmd_code(cmd_code),
      .cmd_write(cmd_write), .cmd_wdata(cmd_wdata), .cmd_read(cmd_read),
      .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
      .cmd_unsupported(cmd_unsupported));
   // Short millisecond so retry chains finish in a few hundred cycles
   power_sequencer #(.MS_CYCLES(MS)) dut (.mclk(mclk), .nrst(nrst),
      .cmd_code(cmd_code), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
      .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
      .cmd_unsupported(cmd_unsupported),
      .output_enable_cmd(output_enable_cmd), .clear_faults(clear_faults),
      .clear_fault_bit(clear_fault_bit), .ext_fault(ext_fault),
      .retry_unit_ms(16'h0001), .pgood_pin_enable(1'b1),
      .vout_code(vout_code), .vout_uv_limit(16'h0400),
      .output_on(output_on), .ramp_active(ramp_active),
      .power_good_output(power_good_output), .pgood_status(pgood_status),
      .ton_fault_flag(ton_fault_flag), .fault_latched(fault_latched));
   task automatic final_report();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // Off with clear, new response byte, then on again
   task automatic restart(input logic [7:0] resp);
      output_enable_cmd <= 1'b0;
      clear_faults <= 1'b1;
      cyc(1);
      clear_faults <= 1'b0;
      host.wr_word(`CMD_TON_RESP, {8'h00, resp});
      base = n_ramp;
      output_enable_cmd <= 1'b1;
   endtask
   task automatic wait_latch();
      for (int k = 0; k < 1500 && fault_latched !== 1'b1; k++) cyc(1);
   endtask
   // Attempt counter and hang guard
   always @(posedge mclk) begin
      ramp_q <= ramp_active;
      if (ramp_active === 1'b1 && ramp_q !== 1'b1) n_ramp <= n_ramp + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      bad = 1'b0;
      cyc(10);
      nrst <= 1'b1;
      cyc(1);
      check("output_on", output_on, 16'h0000);
      check("power_good", power_good_output, 16'h0000);
      for (i = 0; i < 6; i++) begin
         host.rd_word(8'h5E + 8'(i), rd, st);
         check("reset_value", rd, 16'h0000);
         check("read_status", st, 16'h0002);
      end
      host.rd_word(8'h64, rd, st);
      check("unsupported", {14'h0000, st}, 16'h0003);
      check("unsupported_data", rd, 16'h0000);
      for (i = 0; i < 5; i++) host.wr_word(8'h5E + 8'(i), 16'hC3A0 + 16'(i));
      host.wr_word(`CMD_TON_RESP, 16'hFFAA);
      for (i = 0; i < 6; i++) begin
         host.rd_word(8'h5E + 8'(i), rd, st);
         check("readback", rd, i < 5 ? 16'hC3A0 + 16'(i) : 16'h00AA);
      end
      host.wr_word(`CMD_PGOOD_ON, 16'h0800);
      host.wr_word(`CMD_PGOOD_OFF, 16'h0600);
      host.wr_word(`CMD_ON_DELAY, 16'h0002);
      host.wr_word(`CMD_ON_RAMP, 16'h0002);
      host.wr_word(`CMD_TON_MAX, 16'h0000);
      host.wr_word(`CMD_TON_RESP, 16'h0080);
      output_enable_cmd <= 1'b1;
      for (t = 0; t < 60 && ramp_active !== 1'b1; t++) begin
         bad = bad | output_on | power_good_output;
         cyc(1);
      end
      check("delay_len", t >= MS && t <= 2 * MS + 4, 16'h0001);
      for (t = 0; t < 60 && ramp_active === 1'b1; t++) begin
         bad = bad | power_good_output;
         cyc(1);
      end
      check("rise_len", t >= MS && t <= 2 * MS + 4, 16'h0001);
      check("pg_early", bad, 16'h0000);
      cyc(200);
      check("no_timeout", {output_on, ton_fault_flag}, 16'h0002);
      vout_code <= 16'h0900;
      cyc(3);
      check("pg_on", power_good_output, 16'h0001);
      clear_faults <= 1'b1;
      cyc(1);
      clear_faults <= 1'b0;
      vout_code <= 16'h0700;
      cyc(3);
      check("pg_hold", {power_good_output, pgood_status}, 16'h0002);
      vout_code <= 16'h0500;
      cyc(3);
      check("pg_off", {power_good_output, pgood_status}, 16'h0001);
      vout_code <= 16'h0000;
      host.wr_word(`CMD_ON_DELAY, 16'h0000);
      host.wr_word(`CMD_ON_RAMP, 16'h0064);
      host.wr_word(`CMD_TON_MAX, 16'h0002);
      // Retry codes 101, 110, 000 and responses 11, 01 all end latched
      for (i = 0; i < 5; i++) begin
         restart(resps[i]);
         wait_latch();
         check("latched", {fault_latched, output_on}, 16'h0002);
         check("attempts", 16'(n_ramp - base), 16'(exp_ramps[i]));
         check("ton_fault", ton_fault_flag, 16'h0001);
      end
      clear_fault_bit <= 1'b1;
      cyc(1);
      clear_fault_bit <= 1'b0;
      base = n_ramp;
      cyc(3);
      check("cleared", fault_latched, 16'h0000);
      wait_latch();
      check("full_retries", 16'(n_ramp - base), 16'h0002);
      restart(8'h00);
      cyc(300);
      check("ignore_on", output_on, 16'h0001);
      check("ignore", 16'(n_ramp - base), 16'h0001);
      restart(8'hB8);
      cyc(600);
      check("forever", {fault_latched, n_ramp - base > 8}, 16'h0001);
      output_enable_cmd <= 1'b0;
      cyc(3);
      check("stop", output_on, 16'h0000);
      // Passing fault with good output: run on, then back to steady on
      vout_code <= 16'h0900;
      restart(8'h48);
      cyc(20);
      ext_fault <= 1'b1;
      cyc(1);
      ext_fault <= 1'b0;
      cyc(30);
      check("run_on", {output_on, ramp_active, fault_latched}, 16'h0004);
      vout_code <= 16'h0000;
      for (i = 0; i < 4; i += 3) begin
         restart(8'hB8 | 8'(i));
         for (t = 0; t < 200 && output_on !== 1'b1; t++) cyc(1);
         for (t = 0; t < 200 && output_on === 1'b1; t++) cyc(1);
         for (t = 0; t < 300 && ramp_active !== 1'b1; t++) cyc(1);
         check("gap", t >= (MS << i) - MS && t <= (MS << i) + 2 * MS, 16'h0001);
      end
      final_report();
   end
endmodule
`default_nettype wire
